// >>> dv/i2so_bus_master.sv
module i2so_bus_master (
	output logic      m_scl,
	output logic      m_sda,
	input  wire logic scl_w,
	input  wire logic sda_w
);
	timeunit 1ns;
	timeprecision 1ns;
	// Low phase must cover the slave's pin filter and its drive delay,
	// or an ACK or data bit lands while SCL is high and reads as a start or a stop
	int t_lo = 480;
	initial begin
		m_scl = 1'b1;
		m_sda = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic start();
		m_sda = 1'b1;
		m_scl = 1'b1;
		#160;
		m_sda = 1'b0;
		#160;
		m_scl = 1'b0;
		#(t_lo / 2);
	endtask : start
	task automatic stop();
		m_sda = 1'b0;
		#(t_lo / 2);
		m_scl = 1'b1;
		#160;
		m_sda = 1'b1;
		#160;
	endtask : stop
	// SDA moves mid low phase, is read at the end of the high phase
	task automatic tick(input logic b, output logic s);
		m_sda = b;
		#(t_lo / 2);
		m_scl = 1'b1;
		// Slave may stretch; give up after 80 us
		for (int i = 0; i < 2000 && scl_w !== 1'b1; i++) #40;
		#160;
		s = sda_w;
		m_scl = 1'b0;
		#(t_lo / 2);
	endtask : tick
	task automatic xfer(input logic [7:0] d, input logic ma,
		output logic [7:0] r, output logic ak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			tick(d[i], s);
			r[i] = s;
		end
		tick(ma, s);
		ak = !s;
	endtask : xfer
endmodule : i2so_bus_master

// >>> dv/i2so_slave_ctrl_asserts.sv
module i2so_slave_ctrl_chk (
	input wire logic                 core_clk,
	input wire logic                 rst,
	input wire i2so_pkg::i2so_addr_t reg_addr,
	input wire i2so_pkg::i2so_word_t reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire i2so_pkg::i2so_word_t reg_rdata,
	input wire logic                 irq,
	input wire logic                 scl_in,
	input wire logic                 scl_oe_n,
	input wire logic                 sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] opt_q;
	logic [3:0] msk_q;
	logic [3:0] low_q;
	logic [1:0] rel_q;
	wire        wr_ctl = reg_wr && reg_addr == 4'h0;
	// Shadow copies: the checker cannot see the register file itself
	always_ff @(posedge core_clk) begin
		if (rst) begin
			opt_q <= 7'h00;
			msk_q <= 4'h0;
			rel_q <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == 4'h1) opt_q <= reg_wdata[6:0];
			if (reg_wr && reg_addr == 4'h5) msk_q <= reg_wdata[3:0];
			rel_q <= {rel_q[0], wr_ctl};
		end
	end
	always_ff @(posedge core_clk) begin
		if (scl_in) low_q <= 4'h0;
		else if (low_q != 4'hF) low_q <= low_q + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_OPT_UPPER: assert property (
		reg_rd && reg_addr == 4'h1 |=> reg_rdata[15:7] == 9'h000
	) else $error("options upper bits set");
	AST_RD_QUIET: assert property (
		!reg_rd |=> reg_rdata == 16'h0000
	) else $error("read data without read");
	AST_SDA_HOLD: assert property (
		opt_q[3] && $changed(sda_oe_n) |-> low_q >= 4'h8
	) else $error("sda moved too soon after scl fall");
	AST_HOLD_CAUSE: assert property (
		$fell(scl_oe_n) |-> (opt_q[1] || opt_q[0]) && !scl_in
	) else $error("scl held without hold enable");
	AST_HOLD_KEEP: assert property (
		!scl_oe_n && rel_q == 2'b00 && !wr_ctl |=> !scl_oe_n
	) else $error("scl freed without software");
	AST_HOLD_FREE: assert property (
		!scl_oe_n && wr_ctl && reg_wdata[12] |-> ##[1:2] scl_oe_n
	) else $error("scl not freed by clock release");
	AST_EDGE_IRQ: assert property (
		opt_q[6:5] == 2'b00 && msk_q[3:2] == 2'b00 |=> !$rose(irq)
	) else $error("start or stop irq while disabled");
	AST_IRQ_MASKED: assert property (
		msk_q == 4'h0 |=> !irq
	) else $error("irq with all sources masked");
endmodule : i2so_slave_ctrl_chk

bind i2so_slave_ctrl i2so_slave_ctrl_chk u_chk (
	.core_clk,
	.rst,
	.reg_addr,
	.reg_wdata,
	.reg_wr,
	.reg_rd,
	.reg_rdata,
	.irq,
	.scl_in,
	.scl_oe_n,
	.sda_oe_n
);

// >>> dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import i2so_pkg::*;
	logic       core_clk;
	logic       rst;
	i2so_addr_t reg_addr;
	i2so_word_t reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	i2so_word_t reg_rdata;
	logic       irq;
	logic       scl_out;
	logic       scl_oe_n;
	logic       sda_out;
	logic       sda_oe_n;
	logic       m_scl;
	logic       m_sda;
	// Pull-ups: a released line reads high
	wire        scl_w = m_scl & (scl_oe_n | scl_out);
	wire        sda_w = m_sda & (sda_oe_n | sda_out);
	i2so_word_t rv;
	logic [7:0] rb;
	logic       ak;
	int         miscompares = 0;
	int         n_tests = 0;
	int         cyc = 0;
	i2so_slave_ctrl uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .irq, .scl_in(scl_w), .scl_out, .scl_oe_n,
		.sda_in(sda_w), .sda_out, .sda_oe_n);
	i2so_bus_master mst (.m_scl, .m_sda, .scl_w, .sda_w);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input i2so_word_t s, i2so_word_t e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input i2so_addr_t a, input i2so_word_t d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input i2so_addr_t a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		rv = reg_rdata;
	endtask : rd
	task automatic wbyte(input logic [7:0] d);
		mst.xfer(d, 1'b1, rb, ak);
		chk("ack", 16'(ak), 16'h0001);
	endtask : wbyte
	task automatic end_sim();
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		rd(4'h1);
		chk("opt", rv, 16'h0000);
		wr(4'h1, 16'hFFFF);
		rd(4'h1);
		chk("opt", rv, 16'h007F);
		rd(4'hF);
		chk("gap", rv, 16'h0000);
		wr(4'h2, 16'h002A);
		wr(4'h0, 16'h9000);
		wr(4'h5, 16'h0003);
		for (int en = 0; en < 3; en++) begin
			wr(4'h1, (en == 1) ? 16'h0040 :
				(en == 2) ? 16'h0020 : 16'h0000);
			mst.start();
			wbyte(8'h54);
			rd(4'h6);
			chk("rx", rv, 16'h0054);
			wbyte(8'hC3);
			mst.stop();
			rd(4'h6);
			chk("rx", rv, 16'h00C3);
			rd(4'h4);
			chk("ist", rv, (en == 1) ? 16'h000A :
				(en == 2) ? 16'h0009 : 16'h0008);
			chk("irq", 16'(irq), 16'(en != 0));
			wr(4'h4, 16'h000F);
			rd(4'h4);
			chk("ist", rv, 16'h0000);
		end
		// Address byte fills the buffer, so the next byte is refused
		for (int ow = 0; ow < 2; ow++) begin
			wr(4'h1, ow ? 16'h0010 : 16'h0000);
			mst.start();
			wbyte(8'h54);
			mst.xfer(8'h11, 1'b1, rb, ak);
			chk("nack", 16'(ak), 16'h0000);
			rd(4'h3);
			chk("ovf", rv & 16'h0003, 16'h0003);
			rd(4'h6);
			chk("rx", rv, 16'h0054);
			// A refused byte ends the transfer, so address again
			mst.start();
			mst.xfer(8'h54, 1'b1, rb, ak);
			chk("ow", 16'(ak), 16'(ow));
			mst.stop();
			rd(4'h3);
			chk("full", rv & 16'h0001, 16'(ow));
			rd(4'h6);
			wr(4'h3, 16'h0006);
		end
		// Long low phase so a 300 ns hold still meets the setup
		mst.t_lo = 800;
		wr(4'h1, 16'h000B);
		fork
			begin
				mst.start();
				wbyte(8'h54);
				wbyte(8'h3C);
				mst.stop();
			end
			for (int k = 0; k < 2; k++) begin
				for (int i = 0; i < 4000 && scl_oe_n !== 1'b0; i++)
					@(posedge core_clk);
				chk("held", 16'(scl_oe_n), 16'h0000);
				rd(4'h0);
				chk("rel", rv & 16'h1000, 16'h0000);
				rd(4'h6);
				chk("rx", rv, k ? 16'h003C : 16'h0054);
				wr(4'h0, 16'h9000);
				repeat (3) @(posedge core_clk);
			end
		join
		mst.t_lo = 480;
		wr(4'h7, 16'h00A5);
		for (int cd = 0; cd < 2; cd++) begin
			wr(4'h1, cd ? 16'h0004 : 16'h0000);
			mst.start();
			wbyte(8'h55);
			// Released data bits let the sent byte through
			mst.xfer(cd ? 8'h00 : 8'hFF, 1'b1, rb, ak);
			chk("tx", 16'(rb), cd ? 16'h0000 : 16'h00A5);
			mst.stop();
			rd(4'h3);
			chk("bcl", rv & 16'h0004, cd ? 16'h0004 : 16'h0000);
			rd(4'h6);
			wr(4'h3, 16'h0006);
		end
		// Byte and collision status still pending: only the mask gates irq
		wr(4'h5, 16'h000C);
		rd(4'h4);
		chk("ist", rv, 16'h000C);
		chk("irq", 16'(irq), 16'h0001);
		wr(4'h5, 16'h0000);
		rd(4'h4);
		chk("irq", 16'(irq), 16'h0000);
		end_sim();
	end
endmodule : testbench

// >>> logic/i2so_defs.svh
`ifndef I2SO_DEFS_SVH
`define I2SO_DEFS_SVH
//
// Contract
// R1: With the stop interrupt enable set in slave mode, a stop condition raises the interrupt, otherwise it does not.
// R2: With buffer overwrite set, a received byte is loaded and acknowledged whenever receive full is clear regardless of overflow, otherwise only while overflow is also clear.
// R3: With the SDA hold select set, SDA stays stable for at least 300 ns after each falling SCL edge.
// R4: With collision detection set, SDA sampled low on a rising SCL edge while the slave drives high during data transmit sets the collision flag and sends the slave idle.
// R5: With address hold set, after the 8th falling SCL edge of a matching address byte the clock release bit is cleared and SCL held low until software sets it.
// R6: With data hold set, after the 8th falling SCL edge of a received data byte the clock release bit (bit 12) is cleared and SCL held low.
// R7: Bits 15 to 7 of the slave options register read as zero and ignore writes.
// R8: With the start interrupt enable set in slave mode, a start or repeated start raises the interrupt, otherwise it does not.
//
////////////////////////////////////////////////////////////////////////////////
// Register word addresses
`define I2SO_ADDR_CTRL_LO   4'h0
`define I2SO_ADDR_OPTIONS   4'h1
`define I2SO_ADDR_OWN       4'h2
`define I2SO_ADDR_STATUS    4'h3
`define I2SO_ADDR_IRQ_STAT  4'h4
`define I2SO_ADDR_IRQ_MASK  4'h5
`define I2SO_ADDR_RX        4'h6
`define I2SO_ADDR_TX        4'h7

// Lower control fields
`define I2SO_CTRL_ENABLE    15
`define I2SO_CTRL_RELEASE   12
`define I2SO_CTRL_RESET     16'h1000

// Slave options fields
`define I2SO_OPT_STOP_IRQ   6
`define I2SO_OPT_START_IRQ  5
`define I2SO_OPT_OVERWRITE  4
`define I2SO_OPT_SDA_HOLD   3
`define I2SO_OPT_COLLISION  2
`define I2SO_OPT_ADDR_HOLD  1
`define I2SO_OPT_DATA_HOLD  0
`define I2SO_OPT_MASK       16'h007F
`define I2SO_OPT_RESET      16'h0000

// Status fields
`define I2SO_ST_FULL        0
`define I2SO_ST_OVERFLOW    1
`define I2SO_ST_COLLISION   2
`define I2SO_ST_READ        3

// Interrupt status and mask fields
`define I2SO_IRQ_START      0
`define I2SO_IRQ_STOP       1
`define I2SO_IRQ_COLLISION  2
`define I2SO_IRQ_BYTE       3
`define I2SO_IRQ_W          4

`define I2SO_OWN_RESET      7'h00
`define I2SO_TX_RESET       8'hFF

// Timing
`define I2SO_CLK_PERIOD_NS  40
`define I2SO_SDA_HOLD_NS    300
`define I2SO_SDA_HOLD_CYC \
	((`I2SO_SDA_HOLD_NS + `I2SO_CLK_PERIOD_NS - 1) / `I2SO_CLK_PERIOD_NS)
`define I2SO_BITS_PER_BYTE  4'h8

`endif

// >>> logic/i2so_pin_filter.sv
module i2so_pin_filter (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [1:0] pin_in,
	output logic      [1:0] pin_out
);
	import i2so_pkg::*;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic out_q;
			// Stage one feeds only stage two; a change counts once two and
			// three agree, so a single-sample glitch never reaches out_q
			always_ff @(posedge core_clk) begin
				if (rst) begin
					s1_q  <= 1'b1;
					s2_q  <= 1'b1;
					s3_q  <= 1'b1;
					out_q <= 1'b1;
				end else begin
					s1_q <= pin_in[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						out_q <= s3_q;
					end
				end
			end
			assign pin_out[g] = out_q;
		end
	endgenerate

endmodule : i2so_pin_filter

// >>> logic/i2so_pkg.sv
package i2so_pkg;

	typedef logic [3:0]  i2so_addr_t;
	typedef logic [15:0] i2so_word_t;
	typedef logic [7:0]  i2so_byte_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_RX,
		ST_ACK_OUT,
		ST_TX,
		ST_ACK_IN
	} i2so_state_e;

endpackage : i2so_pkg

// >>> logic/i2so_slave_ctrl.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`include "i2so_defs.svh"

module i2so_slave_ctrl (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire i2so_pkg::i2so_addr_t reg_addr,
	input  wire i2so_pkg::i2so_word_t reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output i2so_pkg::i2so_word_t   reg_rdata,
	output logic                   irq,
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe_n,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe_n
);
	import i2so_pkg::*;

	function automatic logic reg_hit(input i2so_addr_t a,
		input i2so_addr_t o);
		reg_hit = (a == o);
	endfunction : reg_hit

	////////////////////////////////////////////////////////////////////////
	// Pin sampling and bus events

	logic [1:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic        scl_prev_q;
	logic        sda_prev_q;

	i2so_pin_filter u_filter (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   ({scl_in, sda_in}),
		.pin_out  (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	////////////////////////////////////////////////////////////////////////
	// Registers

	i2so_word_t  ctrl_q;
	i2so_word_t  opt_q;
	logic [6:0]  own_q;
	i2so_byte_t  tx_q;
	i2so_byte_t  rx_q;
	logic        full_q;
	logic        ovf_q;
	logic        coll_q;
	logic        rd_dir_q;
	logic [`I2SO_IRQ_W-1:0] istat_q;
	logic [`I2SO_IRQ_W-1:0] imask_q;
	i2so_word_t  rdata_q;
	logic        irq_q;

	logic wr_ctrl;
	logic wr_opt;
	logic wr_own;
	logic wr_stat;
	logic wr_istat;
	logic wr_imask;
	logic wr_tx;
	logic rd_rx;

	assign wr_ctrl  = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_CTRL_LO);
	assign wr_opt   = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_OPTIONS);
	assign wr_own   = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_OWN);
	assign wr_stat  = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_STATUS);
	assign wr_istat = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_IRQ_STAT);
	assign wr_imask = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_IRQ_MASK);
	assign wr_tx    = reg_wr & reg_hit(reg_addr, `I2SO_ADDR_TX);
	assign rd_rx    = reg_rd & reg_hit(reg_addr, `I2SO_ADDR_RX);

	logic enable;
	logic release_bit;
	logic en_stop_irq;
	logic en_start_irq;
	logic en_overwrite;
	logic en_sda_hold;
	logic en_collision;
	logic en_addr_hold;
	logic en_data_hold;

	assign enable       = ctrl_q[`I2SO_CTRL_ENABLE];
	assign release_bit  = ctrl_q[`I2SO_CTRL_RELEASE];
	assign en_stop_irq  = opt_q[`I2SO_OPT_STOP_IRQ];
	assign en_start_irq = opt_q[`I2SO_OPT_START_IRQ];
	assign en_overwrite = opt_q[`I2SO_OPT_OVERWRITE];
	assign en_sda_hold  = opt_q[`I2SO_OPT_SDA_HOLD];
	assign en_collision = opt_q[`I2SO_OPT_COLLISION];
	assign en_addr_hold = opt_q[`I2SO_OPT_ADDR_HOLD];
	assign en_data_hold = opt_q[`I2SO_OPT_DATA_HOLD];

	////////////////////////////////////////////////////////////////////////
	// Slave state machine

	i2so_state_e state_q;
	logic [3:0]  cnt_q;
	i2so_byte_t  sh_q;
	i2so_byte_t  tx_sh_q;
	logic        want_low_q;
	logic        is_addr_q;
	logic        mack_q;

	logic byte_done;
	logic addr_match;
	logic accept;
	logic collide;
	logic load_byte;
	logic hold_clr;

	assign byte_done  = scl_fall & (cnt_q == `I2SO_BITS_PER_BYTE) &
		((state_q == ST_ADDR) | (state_q == ST_RX));
	assign addr_match = (sh_q[7:1] == own_q);
	// Overwrite mode ignores a pending overflow, not a full buffer
	assign accept     = ~full_q & (en_overwrite | ~ovf_q); // [R2]
	assign load_byte  = byte_done & accept &
		((state_q == ST_RX) | addr_match); // [R2]
	// Only checked while sending data bits; an ACK we send is a low drive
	assign collide    = enable & en_collision & (state_q == ST_TX) &
		scl_rise & sda_oe_n & ~sda_s; // [R4]
	assign hold_clr   = byte_done &
		(((state_q == ST_ADDR) & addr_match & en_addr_hold) | // [R5]
		((state_q == ST_RX) & en_data_hold)); // [R6]

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			tx_sh_q    <= 8'h00;
			want_low_q <= 1'b0;
			is_addr_q  <= 1'b0;
			mack_q     <= 1'b0;
			rd_dir_q   <= 1'b0;
		end else if (~enable | stop_det | collide) begin
			state_q    <= ST_IDLE; // [R4]
			want_low_q <= 1'b0;
			cnt_q      <= 4'h0;
		end else if (start_det) begin
			state_q    <= ST_ADDR;
			want_low_q <= 1'b0;
			cnt_q      <= 4'h0;
		end else begin
			if (scl_rise) begin
				cnt_q <= cnt_q + 4'h1;
				sh_q  <= {sh_q[6:0], sda_s};
				if (state_q == ST_ACK_IN) begin
					mack_q <= ~sda_s;
				end
			end
			if (scl_fall) begin
				case (state_q)
					ST_ADDR, ST_RX: begin
						if (byte_done) begin
							is_addr_q  <= (state_q == ST_ADDR);
							if (state_q == ST_ADDR) begin
								rd_dir_q <= sh_q[0];
							end
							if (load_byte) begin
								state_q    <= ST_ACK_OUT;
								want_low_q <= 1'b1; // [R2]
							end else begin
								state_q    <= ST_IDLE;
								want_low_q <= 1'b0;
							end
						end
					end
					ST_ACK_OUT: begin
						cnt_q <= 4'h0;
						if (is_addr_q & rd_dir_q) begin
							state_q    <= ST_TX;
							want_low_q <= ~tx_q[7];
							tx_sh_q    <= {tx_q[6:0], 1'b0};
						end else begin
							state_q    <= ST_RX;
							want_low_q <= 1'b0;
						end
					end
					ST_TX: begin
						if (cnt_q == `I2SO_BITS_PER_BYTE) begin
							state_q    <= ST_ACK_IN;
							want_low_q <= 1'b0;
						end else begin
							want_low_q <= ~tx_sh_q[7];
							tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
						end
					end
					ST_ACK_IN: begin
						cnt_q <= 4'h0;
						if (mack_q) begin
							state_q    <= ST_TX;
							want_low_q <= ~tx_q[7];
							tx_sh_q    <= {tx_q[6:0], 1'b0};
						end else begin
							state_q <= ST_IDLE;
						end
					end
					ST_IDLE: begin
						want_low_q <= 1'b0;
					end
					default: begin
						state_q    <= ST_IDLE;
						want_low_q <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers

	// A new SDA level waits out the hold count restarted by every SCL fall
	logic [3:0] hold_cnt_q;
	logic       scl_hold;

	assign scl_hold = enable & ~release_bit & (state_q != ST_IDLE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			hold_cnt_q <= 4'h0;
			sda_oe_n   <= 1'b1;
			scl_oe_n   <= 1'b1;
			sda_out    <= 1'b0;
			scl_out    <= 1'b0;
		end else begin
			if (scl_fall) begin
				hold_cnt_q <= en_sda_hold ?
					4'(`I2SO_SDA_HOLD_CYC) : 4'h0; // [R3]
			end else if (hold_cnt_q != 4'h0) begin
				hold_cnt_q <= hold_cnt_q - 4'h1; // [R3]
			end
			if ((hold_cnt_q == 4'h0) & ~scl_fall) begin
				sda_oe_n <= ~want_low_q; // [R3]
			end
			scl_oe_n <= ~scl_hold; // [R5] [R6]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes and flags

	logic [`I2SO_IRQ_W-1:0] ev;

	assign ev[`I2SO_IRQ_START]     = enable & start_det & en_start_irq; // [R8]
	assign ev[`I2SO_IRQ_STOP]      = enable & stop_det & en_stop_irq; // [R1]
	assign ev[`I2SO_IRQ_COLLISION] = collide;
	assign ev[`I2SO_IRQ_BYTE]      = load_byte;

	logic ovf_set;

	assign ovf_set = byte_done & full_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q  <= `I2SO_CTRL_RESET;
			opt_q   <= `I2SO_OPT_RESET;
			own_q   <= `I2SO_OWN_RESET;
			tx_q    <= `I2SO_TX_RESET;
			rx_q    <= 8'h00;
			full_q  <= 1'b0;
			ovf_q   <= 1'b0;
			coll_q  <= 1'b0;
			istat_q <= '0;
			imask_q <= '0;
		end else begin
			if (hold_clr) begin
				ctrl_q[`I2SO_CTRL_RELEASE] <= 1'b0; // [R5] [R6]
			end else if (wr_ctrl) begin
				ctrl_q <= reg_wdata & `I2SO_CTRL_RESET |
					reg_wdata & (16'h0001 << `I2SO_CTRL_ENABLE);
			end
			if (wr_opt) begin
				opt_q <= reg_wdata & `I2SO_OPT_MASK; // [R7]
			end
			if (wr_own) begin
				own_q <= reg_wdata[6:0];
			end
			if (wr_tx) begin
				tx_q <= reg_wdata[7:0];
			end
			if (load_byte) begin
				rx_q <= sh_q; // [R2]
			end
			full_q <= load_byte | (full_q & ~rd_rx);
			ovf_q  <= ovf_set |
				(ovf_q & ~(wr_stat & reg_wdata[`I2SO_ST_OVERFLOW]));
			coll_q <= collide |
				(coll_q & ~(wr_stat & reg_wdata[`I2SO_ST_COLLISION])); // [R4]
			istat_q <= ev |
				(istat_q & ~({`I2SO_IRQ_W{wr_istat}} &
				reg_wdata[`I2SO_IRQ_W-1:0])); // [R1] [R8]
			if (wr_imask) begin
				imask_q <= reg_wdata[`I2SO_IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path and interrupt

	i2so_word_t rd_mux;
	i2so_word_t status_word;

	assign status_word = {12'h000, rd_dir_q, coll_q, ovf_q, full_q};

	assign rd_mux =
		reg_hit(reg_addr, `I2SO_ADDR_CTRL_LO)  ? ctrl_q :
		reg_hit(reg_addr, `I2SO_ADDR_OPTIONS)  ? opt_q :
		reg_hit(reg_addr, `I2SO_ADDR_OWN)      ? {9'h000, own_q} :
		reg_hit(reg_addr, `I2SO_ADDR_STATUS)   ? status_word :
		reg_hit(reg_addr, `I2SO_ADDR_IRQ_STAT) ? {12'h000, istat_q} :
		reg_hit(reg_addr, `I2SO_ADDR_IRQ_MASK) ? {12'h000, imask_q} :
		reg_hit(reg_addr, `I2SO_ADDR_RX)       ? {8'h00, rx_q} :
		reg_hit(reg_addr, `I2SO_ADDR_TX)       ? {8'h00, tx_q} :
		16'h0000;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 16'h0000;
			irq_q   <= |(istat_q & imask_q);
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

endmodule : i2so_slave_ctrl
